// file: hdl/host_port_pkg.sv
// constants for the host port, interrupt request and serial output gating
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package host_port_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 11;
  localparam int IRQ_W = 8;
  localparam int IRQ_DEPTH = 16;
  localparam int CHANNELS = 8;
  localparam int SLOT_BITS = 8;
  localparam int FRAME_BITS = 256;
  localparam logic [ADDR_W-1:0] MAIN_CTRL_ADDR = 11'h400;
  localparam logic [ADDR_W-1:0] IRQ_FIFO_ADDR = 11'h401;
  localparam logic [ADDR_W-1:0] SEND_BASE_ADDR = 11'h410;
  localparam logic [ADDR_W-1:0] RECV_BASE_ADDR = 11'h418;
  localparam int OUT_EN_BIT = 6;
  localparam logic [DATA_W-1:0] MAIN_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] EMPTY_READ = 8'h00;
  localparam logic [1:0] ACK_DELAY = 2'h2;
  localparam logic [2:0] FMT_LONG = 3'h2;
  localparam logic [IRQ_W-1:0] IRQ_TAG = 8'h80;
  localparam logic [ADDR_W-1:0] SLOT_ADDR_MASK = 11'h7F8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACK = 3'b100
  } port_state_t;
endpackage

// file: hdl/event_fifo.sv
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module event_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;
  fifo_state_t s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push, pop;

  // handshakes from the count so full and empty are exact
  assign in_ready_o = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o = mem_q[s_q.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer and count update
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.wr = AW'(s_q.wr + 1'b1);
    end
    if (pop)
    begin
      s_d.rd = AW'(s_q.rd + 1'b1);
    end
    s_d.cnt = (AW+1)'(s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  // state register
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem_q[s_q.wr] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// file: hdl/host_port_irq_output_enable.sv
// host port, interrupt request and serial stream output gating
`timescale 1ns/1ps
`default_nettype none
module host_port_irq_output_enable (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // host port
  input wire logic chip_select_n_i,
  input wire logic data_strobe_n_i,
  input wire logic read_not_write_i,
  input wire logic [host_port_pkg::ADDR_W-1:0] host_address_bus_i,
  input wire logic [host_port_pkg::DATA_W-1:0] host_data_bus_i,
  output logic [host_port_pkg::DATA_W-1:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  output logic transfer_ack_n_o,
  output logic transfer_ack_n_oe_o,
  // interrupt
  input wire logic [host_port_pkg::CHANNELS-1:0] channel_event_i,
  output logic irq_n_o,
  output logic irq_n_oe_o,
  // serial streams
  input wire logic serial_shift_clock_i,
  input wire logic frame_sync_in_i,
  input wire logic send_in_i,
  input wire logic recv_in_i,
  input wire logic output_drive_gate_i,
  output logic send_out_o,
  output logic send_out_oe_o,
  output logic recv_out_o,
  output logic recv_out_oe_o,
  output logic frame_fmt_long_o
);
  import host_port_pkg::*;

  typedef struct packed {
    port_state_t st;
    logic [1:0] dly;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] send_tx;
    logic [DATA_W-1:0] recv_tx;
    logic [DATA_W-1:0] send_sh;
    logic [DATA_W-1:0] recv_sh;
    logic [DATA_W-1:0] send_rx;
    logic [2:0] bitc;
    logic [2:0] slot;
    logic clk_prev;
    logic fs_prev;
    logic [2:0] fs_len;
    logic fmt_long;
    logic send_bit;
    logic recv_bit;
  } core_state_t;
  core_state_t s_q, s_d;

  logic access;
  logic ev_valid, ev_ready, fifo_valid, fifo_pop;
  logic [IRQ_W-1:0] ev_code, fifo_data;
  logic clk_rise, clk_fall, out_en;

  // ----------------------------------------------------------------------
  // pin decode
  // ----------------------------------------------------------------------
  // an access exists only while strobe and select are both low
  assign access = !chip_select_n_i && !data_strobe_n_i;
  assign clk_rise = serial_shift_clock_i && !s_q.clk_prev;
  assign clk_fall = !serial_shift_clock_i && s_q.clk_prev;

  // ----------------------------------------------------------------------
  // interrupt queue
  // ----------------------------------------------------------------------
  // lowest pending channel enters the interrupt queue; a full queue drops it
  always_comb
  begin
    ev_valid = 1'b0;
    ev_code = '0;
    for (int i = CHANNELS - 1; i >= 0; i--)
    begin
      if (channel_event_i[i])
      begin
        ev_valid = 1'b1;
        ev_code = IRQ_W'(i) | IRQ_TAG;
      end
    end
  end

  // one read of the fifo register pops one entry in the last wait cycle before ack
  assign fifo_pop = (s_q.st == ST_WAIT) && (s_q.dly == '0) && read_not_write_i
                    && (host_address_bus_i == IRQ_FIFO_ADDR) && access;

  event_fifo #(
    .WIDTH(IRQ_W),
    .DEPTH(IRQ_DEPTH)
  ) u_irq_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(ev_valid),
    .in_ready_o(ev_ready),
    .in_data_i(ev_code),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  // pin and control bit are anded for both outputs
  assign out_en = output_drive_gate_i && s_q.ctrl[OUT_EN_BIT];

  // ----------------------------------------------------------------------
  // port sequencer and serial engine
  // ----------------------------------------------------------------------
  // port sequencing, control register and serial engine
  always_comb
  begin
    s_d = s_q;
    s_d.clk_prev = serial_shift_clock_i;
    unique case (s_q.st)
      ST_IDLE:
      begin
        if (access)
        begin
          s_d.st = ST_WAIT;
          s_d.dly = ACK_DELAY;
        end
      end
      ST_WAIT:
      begin
        if (!access)
        begin
          s_d.st = ST_IDLE;
        end
        else if (s_q.dly != '0)
        begin
          s_d.dly = 2'(s_q.dly - 1'b1);
        end
        else
        begin
          s_d.st = ST_ACK;
          if (read_not_write_i)
          begin
            if (host_address_bus_i == MAIN_CTRL_ADDR)
            begin
              s_d.rdata = s_q.ctrl;
            end
            else if (host_address_bus_i == IRQ_FIFO_ADDR)
            begin
              s_d.rdata = fifo_valid ? fifo_data : EMPTY_READ;
            end
            else
            begin
              s_d.rdata = EMPTY_READ;
            end
          end
          else if (host_address_bus_i == MAIN_CTRL_ADDR)
          begin
            s_d.ctrl = host_data_bus_i;
          end
          else if ((host_address_bus_i & SLOT_ADDR_MASK) == SEND_BASE_ADDR)
          begin
            s_d.send_tx = host_data_bus_i;
          end
          else if ((host_address_bus_i & SLOT_ADDR_MASK) == RECV_BASE_ADDR)
          begin
            s_d.recv_tx = host_data_bus_i;
          end
        end
      end
      ST_ACK:
      begin
        if (!access)
        begin
          s_d.st = ST_IDLE;
        end
      end
    endcase
    // frame pulse width in shift clocks tells the two formats apart
    if (clk_rise)
    begin
      s_d.fs_prev = frame_sync_in_i;
      if (frame_sync_in_i)
      begin
        s_d.fs_len = (s_q.fs_len == '1) ? s_q.fs_len : 3'(s_q.fs_len + 1'b1);
      end
      else if (s_q.fs_prev)
      begin
        s_d.fmt_long = (s_q.fs_len >= FMT_LONG);
        s_d.fs_len = '0;
        s_d.bitc = '0;
        s_d.slot = '0;
        s_d.send_sh = s_q.send_tx;
        s_d.recv_sh = s_q.recv_tx;
      end
      else
      begin
        // one shift clock per bit: send input shifts in on each rising edge outside the frame pulse except the first one after it
        s_d.send_rx = {s_q.send_rx[DATA_W-2:0], send_in_i};
      end
    end
    if (clk_fall && !frame_sync_in_i)
    begin
      s_d.send_bit = s_q.send_sh[DATA_W-1];
      s_d.recv_bit = s_q.recv_sh[DATA_W-1];
      s_d.send_sh = {s_q.send_sh[DATA_W-2:0], recv_in_i};
      s_d.recv_sh = {s_q.recv_sh[DATA_W-2:0], send_in_i};
      s_d.bitc = 3'(s_q.bitc + 1'b1);
      if (s_q.bitc == 3'(SLOT_BITS - 1))
      begin
        s_d.slot = 3'(s_q.slot + 1'b1);
        s_d.send_sh = s_q.send_tx;
        s_d.recv_sh = s_q.recv_tx;
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register and pins
  // ----------------------------------------------------------------------
  // state register
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '{st: ST_IDLE, ctrl: MAIN_CTRL_RST, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // pins: open drain outputs only ever drive low
  assign transfer_ack_n_o = 1'b0;
  assign transfer_ack_n_oe_o = (s_q.st == ST_ACK) && access;
  assign host_data_bus_o = s_q.rdata;
  assign host_data_bus_oe_o = (s_q.st == ST_ACK) && access && read_not_write_i;
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = fifo_valid;
  assign send_out_o = s_q.send_bit;
  assign send_out_oe_o = out_en;
  assign recv_out_o = s_q.recv_bit;
  assign recv_out_oe_o = out_en;
  assign frame_fmt_long_o = s_q.fmt_long;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  ack_needs_access_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    transfer_ack_n_oe_o |-> access)
    else $error("ack driven without access");
  bus_drive_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    host_data_bus_oe_o |-> read_not_write_i && transfer_ack_n_oe_o)
    else $error("bus driven outside read ack");
  ack_after_delay_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s_q.st == ST_IDLE && access) ##1 access [*4] |-> transfer_ack_n_oe_o)
    else $error("ack late");
  no_early_ack_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(access) |-> !transfer_ack_n_oe_o)
    else $error("ack too early");
  irq_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (irq_n_oe_o && !fifo_pop) |=> irq_n_oe_o)
    else $error("irq released with entries pending");
  irq_on_event_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_valid && ev_ready) |=> irq_n_oe_o)
    else $error("event did not raise irq");
  serial_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    send_out_oe_o == (output_drive_gate_i && s_q.ctrl[OUT_EN_BIT]))
    else $error("send gate wrong");
  serial_float_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !output_drive_gate_i |-> !recv_out_oe_o && !send_out_oe_o)
    else $error("output driven while gated off");
  ctrl_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s_q.st == ST_WAIT && s_q.dly == '0 && access && !read_not_write_i
     && host_address_bus_i == MAIN_CTRL_ADDR) |=> s_q.ctrl == $past(host_data_bus_i))
    else $error("control write lost");
  // host port handshake
  select_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    chip_select_n_i |-> !transfer_ack_n_oe_o && !host_data_bus_oe_o)
    else $error("port active without select");
  strobe_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    data_strobe_n_i |-> !transfer_ack_n_oe_o && !host_data_bus_oe_o)
    else $error("port active without strobe");
  idle_after_drop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s_q.st != ST_IDLE && !access) |=> s_q.st == ST_IDLE)
    else $error("sequencer kept a dropped access");
  wait_no_ack_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s_q.st != ST_ACK) |-> !transfer_ack_n_oe_o)
    else $error("ack outside ack state");
  rdata_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (host_data_bus_oe_o && $past(host_data_bus_oe_o)) |-> $stable(host_data_bus_o))
    else $error("read data moved while driven");
  ctrl_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(s_q.st == ST_WAIT && s_q.dly == '0 && access && !read_not_write_i
      && host_address_bus_i == MAIN_CTRL_ADDR) |=> $stable(s_q.ctrl))
    else $error("control changed without a write");
  // interrupt and serial streams
  irq_release_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(irq_n_oe_o) |-> $past(fifo_pop))
    else $error("irq released without a queue read");
  fmt_stable_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(clk_rise && !frame_sync_in_i && s_q.fs_prev) |=> $stable(frame_fmt_long_o))
    else $error("format changed outside frame end");
  serial_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(clk_fall && !frame_sync_in_i) |=> ($stable(send_out_o) && $stable(recv_out_o)))
    else $error("serial bit moved off a falling shift edge");
endmodule
`default_nettype wire

// file: test/host_model.sv
// host processor model for the asynchronous register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic sys_clk_i,
  // port pins
  output logic chip_select_n_o,
  output logic data_strobe_n_o,
  output logic read_not_write_o,
  output logic [10:0] host_address_bus_o,
  output logic [7:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  input wire logic transfer_ack_n_i,
  input wire logic [7:0] host_data_bus_i
);
  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  // all qualifiers move together just after a rising edge
  task automatic drive(input logic cs, input logic ds, input logic rnw, input logic [10:0] adr,
                       input logic [7:0] wd);
    chip_select_n_o <= cs;
    data_strobe_n_o <= ds;
    read_not_write_o <= rnw;
    host_address_bus_o <= adr;
    host_data_bus_o <= wd;
    host_data_bus_oe_o <= ~cs & ~ds & ~rnw;
  endtask
  // holds the strobe for at most n cycles; lat is the cycle that saw ack, 0 if none
  task automatic acc(input logic cs, input logic rnw, input logic [10:0] adr, input logic [7:0] wd,
                     input int n, output logic [7:0] rd, output int lat);
    lat = 0;
    @(posedge sys_clk_i);
    drive(cs, 1'b0, rnw, adr, wd);
    for (int i = 1; i <= n && lat == 0; i++)
    begin
      @(negedge sys_clk_i);
      if (transfer_ack_n_i === 1'b0)
        lat = i;
    end
    @(posedge sys_clk_i);
    rd = host_data_bus_i;
    drive(1'b1, 1'b1, rnw, adr, wd);
  endtask
  initial
  begin
    chip_select_n_o = 1'b1;
    data_strobe_n_o = 1'b1;
    read_not_write_o = 1'b1;
    host_address_bus_o = 11'h000;
    host_data_bus_o = 8'h00;
    host_data_bus_oe_o = 1'b0;
  end
endmodule
`default_nettype wire

// file: test/tb_host_port_irq_output_enable.sv
// self-checking bench for the host port, interrupt and output gating
`timescale 1ns/1ps
`default_nettype none
module tb_host_port_irq_output_enable;
  import host_port_pkg::*;
  logic sys_clk_i, rst_i, gate, sck, fsync, sin;
  localparam logic [7:0] SEND_PAT = 8'hA5;
  localparam logic [7:0] RECV_PAT = 8'h3C;
  logic [7:0] ev, rd, last_d;
  int err_total, checks_done, lat;
  wire logic cs_n, ds_n, rnw, hoe, d_oe, ack_n, ack_oe, irq_n, irq_oe, s_o, s_oe, r_o, r_oe;
  wire logic [10:0] adr;
  wire logic [7:0] hwd, d_o, bus;
  wire logic ack_w, irq_w, fmt;
  // ------------------------------------------------------------
  // wires
  // ------------------------------------------------------------
  // a released bus shows the inverse of its last level so stale data cannot pass
  assign bus = d_oe ? d_o : hoe ? hwd : ~last_d;
  assign ack_w = ack_oe ? ack_n : 1'b1; // pull-up
  assign irq_w = irq_oe ? irq_n : 1'b1; // pull-up
  always @(posedge sys_clk_i) last_d <= bus;
  host_model u_host (.sys_clk_i(sys_clk_i), .chip_select_n_o(cs_n), .data_strobe_n_o(ds_n),
    .read_not_write_o(rnw), .host_address_bus_o(adr), .host_data_bus_o(hwd),
    .host_data_bus_oe_o(hoe), .transfer_ack_n_i(ack_w), .host_data_bus_i(bus));
  host_port_irq_output_enable u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .chip_select_n_i(cs_n),
    .data_strobe_n_i(ds_n), .read_not_write_i(rnw), .host_address_bus_i(adr),
    .host_data_bus_i(bus), .host_data_bus_o(d_o), .host_data_bus_oe_o(d_oe),
    .transfer_ack_n_o(ack_n), .transfer_ack_n_oe_o(ack_oe), .channel_event_i(ev),
    .irq_n_o(irq_n), .irq_n_oe_o(irq_oe), .serial_shift_clock_i(sck), .frame_sync_in_i(fsync),
    .send_in_i(sin), .recv_in_i(1'b0), .output_drive_gate_i(gate), .send_out_o(s_o),
    .send_out_oe_o(s_oe), .recv_out_o(r_o), .recv_out_oe_o(r_oe), .frame_fmt_long_o(fmt));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // full access; a missing acknowledge ends the run
  task automatic xfer(input logic rnw, input logic [10:0] a, input logic [7:0] d);
    u_host.acc(1'b0, rnw, a, d, 20, rd, lat);
    chk(8'(lat), 8'h05);
    if (lat == 0)
      final_report();
  endtask
  // one shift clock period spans four system clocks, since the design samples the shift clock
  task automatic shift(input logic fs, output logic [1:0] so);
    sck <= 1'b1;
    fsync <= fs;
    sin <= ~sin;
    repeat (2) @(posedge sys_clk_i);
    sck <= 1'b0;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    so = {s_o, r_o};
    @(posedge sys_clk_i);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk({7'h00, irq_w}, 8'h01);
    chk({6'h00, s_oe, r_oe}, 8'h00);
    xfer(1'b1, MAIN_CTRL_ADDR, 8'h00);
    chk(rd, MAIN_CTRL_RST);
    $display("t_reset done");
  endtask
  task automatic t_ack();
    xfer(1'b0, MAIN_CTRL_ADDR, 8'h5A);
    @(negedge sys_clk_i);
    chk({7'h00, ack_oe}, 8'h00);
    xfer(1'b1, MAIN_CTRL_ADDR, 8'h00);
    chk(rd, 8'h5A);
    @(negedge sys_clk_i);
    chk({6'h00, d_oe, ack_oe}, 8'h00);
    $display("t_ack done");
  endtask
  // every combination of pin and control bit
  task automatic t_gate();
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, MAIN_CTRL_ADDR, i[1] ? 8'h40 : 8'h00);
      gate <= i[0];
      @(negedge sys_clk_i);
      chk({6'h00, s_oe, r_oe}, {6'h00, {2{i[1] & i[0]}}});
    end
    $display("t_gate done");
  endtask
  // strobe without select, and an access dropped before acknowledge
  task automatic t_abort();
    u_host.acc(1'b1, 1'b0, MAIN_CTRL_ADDR, 8'h00, 8, rd, lat);
    chk(8'(lat), 8'h00);
    u_host.acc(1'b0, 1'b0, MAIN_CTRL_ADDR, 8'h00, 2, rd, lat);
    chk(8'(lat), 8'h00);
    xfer(1'b0, 11'h7FF, 8'hA5);
    xfer(1'b1, 11'h7FF, 8'h00);
    chk(rd, 8'h00);
    xfer(1'b1, MAIN_CTRL_ADDR, 8'h00);
    chk(rd, 8'h40);
    $display("t_abort done");
  endtask
  // two events in order, then drain; irq must hold until the last pop
  task automatic t_irq();
    ev <= 8'h20;
    @(posedge sys_clk_i);
    ev <= 8'h04;
    @(posedge sys_clk_i);
    ev <= 8'h00;
    @(negedge sys_clk_i);
    chk({7'h00, irq_w}, 8'h00);
    xfer(1'b1, IRQ_FIFO_ADDR, 8'h00);
    chk(rd, 8'h85);
    chk({7'h00, irq_w}, 8'h00);
    xfer(1'b1, IRQ_FIFO_ADDR, 8'h00);
    chk(rd, 8'h82);
    @(negedge sys_clk_i);
    chk({7'h00, irq_w}, 8'h01);
    $display("t_irq done");
  endtask
  // overfill the queue; only its depth survives
  task automatic t_fill();
    @(posedge sys_clk_i);
    ev <= 8'h01;
    repeat (20) @(posedge sys_clk_i);
    ev <= 8'h00;
    for (int i = 0; i < IRQ_DEPTH; i++)
    begin
      xfer(1'b1, IRQ_FIFO_ADDR, 8'h00);
      chk(rd, 8'h80);
    end
    xfer(1'b1, IRQ_FIFO_ADDR, 8'h00);
    chk(rd, EMPTY_READ);
    chk({7'h00, irq_w}, 8'h01);
    $display("t_fill done");
  endtask
  // a two clock frame pulse then a one clock pulse; stored bytes leave msb first
  task automatic t_serial();
    logic [1:0] so;
    xfer(1'b0, SEND_BASE_ADDR, SEND_PAT);
    xfer(1'b0, RECV_BASE_ADDR, RECV_PAT);
    repeat (2) shift(1'b1, so);
    for (int k = 7; k >= 0; k--)
    begin
      shift(1'b0, so);
      chk({6'h00, so}, {6'h00, SEND_PAT[k], RECV_PAT[k]});
    end
    chk({7'h00, fmt}, 8'h01);
    shift(1'b1, so);
    shift(1'b0, so);
    chk({7'h00, fmt}, 8'h00);
    $display("t_serial done");
  endtask
  initial
  begin
    err_total = 0;
    checks_done = 0;
    rst_i = 1'b1;
    gate = 1'b0;
    sck = 1'b0;
    fsync = 1'b0;
    sin = 1'b0;
    ev = 8'h00;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(negedge sys_clk_i);
    t_reset();
    t_ack();
    t_gate();
    t_abort();
    t_irq();
    t_fill();
    t_serial();
    final_report();
  end
endmodule
`default_nettype wire
